// ==== rtl/dma_ch0_pkg.sv ====
/*
 * Shared constants and types for the channel 0 DMA mode and transfer block.
 * Assumes an 8-bit register port and a 16-bit system address space.
 */
package dma_ch0_pkg;

    // Register offsets on the 8-bit register port.
    localparam logic [7:0] OFF_SRC_LO  = 8'h20;
    localparam logic [7:0] OFF_SRC_HI  = 8'h21;
    localparam logic [7:0] OFF_DST_LO  = 8'h22;
    localparam logic [7:0] OFF_DST_HI  = 8'h23;
    localparam logic [7:0] OFF_CNT_LO  = 8'h24;
    localparam logic [7:0] OFF_CNT_HI  = 8'h25;
    localparam logic [7:0] OFF_STATUS  = 8'h26;
    localparam logic [7:0] OFF_MASK    = 8'h27;
    localparam logic [7:0] OFF_CTRL    = 8'h30;
    localparam logic [7:0] OFF_MODE    = 8'h31;

    // Field positions.
    localparam int DST_HI_BIT   = 5;
    localparam int DST_LO_BIT   = 4;
    localparam int SRC_HI_BIT   = 3;
    localparam int SRC_LO_BIT   = 2;
    localparam int PACE_BIT     = 1;
    localparam int CTRL_EN_BIT  = 0;
    localparam int CTRL_ME_BIT  = 1;
    localparam int STAT_DONE    = 0;
    localparam int STAT_BADMODE = 1;

    // Values after reset and stored-bit masks.
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MODE_MASK  = 8'h3E;
    localparam logic [1:0] STAT_RESET = 2'h0;
    localparam logic [1:0] MASK_RESET = 2'h0;

    // Address mode codes of the source and destination fields.
    localparam logic [1:0] AM_INC   = 2'h0;
    localparam logic [1:0] AM_DEC   = 2'h1;
    localparam logic [1:0] AM_FIXED = 2'h2;
    localparam logic [1:0] AM_IO    = 2'h3;

    // Transfer engine states.
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_READ  = 2'b01,
        S_WRITE = 2'b10,
        S_GIVE  = 2'b11
    } xfer_state_t;

    // One register port request.
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_req_t;

    // One system bus cycle driven by the engine.
    typedef struct packed {
        logic        hold;
        logic        rd;
        logic        wr;
        logic        io;
        logic [15:0] addr;
        logic [7:0]  data;
    } bus_cyc_t;

endpackage

// ==== rtl/dma_channel0_mode_control.sv ====
/*
 * Channel 0 DMA engine: mode register decode, address stepping, byte
 * counting, bus pacing (burst, cycle steal, request paced) and interrupt.
 * Assumes the system bus returns read data in the same cycle as the read
 * strobe and that the request input is synchronous to the clock.
 */
`timescale 1ns/10ps

module dma_channel0_mode_control #(
    parameter int ADDR_W = 16
) (
    // Clock and synchronous reset.
    input  wire logic                   clock,
    input  wire logic                   rst_b,
    // Register port.
    input  wire dma_ch0_pkg::reg_req_t  regReq,
    output logic [7:0]                  regRdata,
    // Peripheral request and master disable (non-maskable event).
    input  wire logic                   ch0ExtRequest,
    input  wire logic                   masterStop,
    // System bus.
    output dma_ch0_pkg::bus_cyc_t       busCyc,
    input  wire logic [7:0]             busRdData,
    // Interrupt to the processor.
    output logic                        irq
);

    // The datapath and register map are built for a 16-bit address only.
    // The check runs at elaboration, so a wrong value never reaches logic.
    if (ADDR_W != 16) begin : g_addr_w_check
        $error("ADDR_W must be 16");
    end

    ////////////////////////////////////////////////////////////////////////
    // Helper functions.

    // Next address for one byte under an address mode code.
    function automatic logic [15:0] stepAddr(input logic [15:0] a, input logic [1:0] m);
        logic [15:0] r;
        r = a;
        case (m)
            dma_ch0_pkg::AM_INC: r = a + 16'h0001;
            dma_ch0_pkg::AM_DEC: r = a - 16'h0001;
            default:             r = a;
        endcase
        return r;
    endfunction

    // Address mode code that means I/O space.
    function automatic logic isIo(input logic [1:0] m);
        return m == dma_ch0_pkg::AM_IO;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0]               modeReg;       // Channel mode register.
    logic [15:0]              srcReg;        // Source address.
    logic [15:0]              dstReg;        // Destination address.
    logic [15:0]              cntReg;        // Bytes left.
    logic                     enReg;         // Channel enable.
    logic                     masterReg;     // Master enable.
    logic [1:0]               statReg;       // Sticky event bits.
    logic [1:0]               maskReg;       // Interrupt mask (enable).
    logic [7:0]               dataReg;       // Byte in flight.
    logic [7:0]               rdataReg;      // Read data, one cycle late.
    dma_ch0_pkg::xfer_state_t stateReg;      // Engine state.
    dma_ch0_pkg::xfer_state_t stateNext;     // Engine state, next.
    dma_ch0_pkg::bus_cyc_t    busReg;        // Registered bus cycle.
    dma_ch0_pkg::bus_cyc_t    busNext;       // Bus cycle, next.

    ////////////////////////////////////////////////////////////////////////
    // Decode.

    wire logic [1:0] dstMode  = modeReg[dma_ch0_pkg::DST_HI_BIT:dma_ch0_pkg::DST_LO_BIT];
    wire logic [1:0] srcMode  = modeReg[dma_ch0_pkg::SRC_HI_BIT:dma_ch0_pkg::SRC_LO_BIT];
    wire logic       burstSel = modeReg[dma_ch0_pkg::PACE_BIT];
    // Both fields at fixed or I/O leaves no address that steps; refuse it.
    wire logic       badMode  = dstMode[1] & srcMode[1];
    // Fixed memory is still memory space, so only code 11 turns on I/O.
    wire logic       ioPaced  = isIo(dstMode) | isIo(srcMode);
    wire logic       running  = enReg & masterReg & ~badMode;
    wire logic       countZero = (cntReg == 16'h0000);
    wire logic       lastByte = (cntReg == 16'h0001);
    // Memory to memory ignores the request pin entirely.
    wire logic       goNow    = running & ~countZero & (~ioPaced | ch0ExtRequest);
    wire logic       byteDone = (stateReg == dma_ch0_pkg::S_WRITE);
    wire logic       finish   = (byteDone & lastByte) | (running & countZero
                                & (stateReg == dma_ch0_pkg::S_IDLE));

    wire logic       wrHit    = regReq.wr;
    wire logic [7:0] wa       = regReq.addr;
    wire logic [7:0] wd       = regReq.wdata;
    wire logic       wCtrl    = wrHit & (wa == dma_ch0_pkg::OFF_CTRL);
    wire logic       wMode    = wrHit & (wa == dma_ch0_pkg::OFF_MODE);
    wire logic       wStat    = wrHit & (wa == dma_ch0_pkg::OFF_STATUS);
    wire logic       wMask    = wrHit & (wa == dma_ch0_pkg::OFF_MASK);
    wire logic       wSrcLo   = wrHit & (wa == dma_ch0_pkg::OFF_SRC_LO);
    wire logic       wSrcHi   = wrHit & (wa == dma_ch0_pkg::OFF_SRC_HI);
    wire logic       wDstLo   = wrHit & (wa == dma_ch0_pkg::OFF_DST_LO);
    wire logic       wDstHi   = wrHit & (wa == dma_ch0_pkg::OFF_DST_HI);
    wire logic       wCntLo   = wrHit & (wa == dma_ch0_pkg::OFF_CNT_LO);
    wire logic       wCntHi   = wrHit & (wa == dma_ch0_pkg::OFF_CNT_HI);
    wire logic       startWr  = wCtrl & wd[dma_ch0_pkg::CTRL_EN_BIT];

    // Stepped values; software writes win over the engine in one cycle.
    wire logic [15:0] srcStep = byteDone ? stepAddr(srcReg, srcMode) : srcReg;
    wire logic [15:0] dstStep = byteDone ? stepAddr(dstReg, dstMode) : dstReg;
    wire logic [15:0] cntStep = byteDone ? cntReg - 16'h0001 : cntReg;
    wire logic [15:0] srcNext = {wSrcHi ? wd : srcStep[15:8], wSrcLo ? wd : srcStep[7:0]};
    wire logic [15:0] dstNext = {wDstHi ? wd : dstStep[15:8], wDstLo ? wd : dstStep[7:0]};
    wire logic [15:0] cntNext = {wCntHi ? wd : cntStep[15:8], wCntLo ? wd : cntStep[7:0]};

    // Enable: termination clears it even against a software write.
    wire logic       enNext   = finish ? 1'b0 : (wCtrl ? wd[dma_ch0_pkg::CTRL_EN_BIT] : enReg);
    // Writing enable 1 also sets master; the stop input clears master.
    wire logic       masterNext = startWr | (masterReg & ~masterStop);

    // Event bits: a set in the clearing cycle survives.
    wire logic [1:0] statSet  = {enReg & badMode, finish};
    wire logic [1:0] statNext = (statReg & ~(wStat ? wd[1:0] : 2'h0)) | statSet;

    // Register read mux; unmapped and reserved bits read zero.
    wire logic [7:0] rdMux =
        (wa == dma_ch0_pkg::OFF_MODE)   ? (modeReg & dma_ch0_pkg::MODE_MASK) :
        (wa == dma_ch0_pkg::OFF_CTRL)   ? {6'h00, masterReg, enReg} :
        (wa == dma_ch0_pkg::OFF_SRC_LO) ? srcReg[7:0] :
        (wa == dma_ch0_pkg::OFF_SRC_HI) ? srcReg[15:8] :
        (wa == dma_ch0_pkg::OFF_DST_LO) ? dstReg[7:0] :
        (wa == dma_ch0_pkg::OFF_DST_HI) ? dstReg[15:8] :
        (wa == dma_ch0_pkg::OFF_CNT_LO) ? cntReg[7:0] :
        (wa == dma_ch0_pkg::OFF_CNT_HI) ? cntReg[15:8] :
        (wa == dma_ch0_pkg::OFF_STATUS) ? {6'h00, statReg} :
        (wa == dma_ch0_pkg::OFF_MASK)   ? {6'h00, maskReg} : 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Engine state machine.

    // Each byte is a read cycle then a write cycle with the bus held.
    always_comb begin
        stateNext = stateReg;
        case (stateReg)
            dma_ch0_pkg::S_IDLE: begin
                if (goNow) begin
                    stateNext = dma_ch0_pkg::S_READ;
                end
            end
            dma_ch0_pkg::S_READ: begin
                stateNext = dma_ch0_pkg::S_WRITE;
            end
            dma_ch0_pkg::S_WRITE: begin
                if (lastByte || !running) begin
                    stateNext = dma_ch0_pkg::S_IDLE;
                end else if (ioPaced) begin
                    // Release the bus and wait for the next request.
                    stateNext = dma_ch0_pkg::S_IDLE;
                end else if (burstSel) begin
                    stateNext = dma_ch0_pkg::S_READ;
                end else begin
                    stateNext = dma_ch0_pkg::S_GIVE;
                end
            end
            dma_ch0_pkg::S_GIVE: begin
                // One cycle for the processor, then steal again.
                stateNext = running ? dma_ch0_pkg::S_READ : dma_ch0_pkg::S_IDLE;
            end
            default: begin
                stateNext = dma_ch0_pkg::S_IDLE;
            end
        endcase
    end

    // Bus cycle for the coming state, registered so the pins are clean.
    always_comb begin
        busNext      = '0;
        busNext.data = dataReg;
        case (stateNext)
            dma_ch0_pkg::S_READ: begin
                busNext.hold = 1'b1;
                busNext.rd   = 1'b1;
                busNext.io   = isIo(srcMode);
                busNext.addr = srcNext;
            end
            dma_ch0_pkg::S_WRITE: begin
                busNext.hold = 1'b1;
                busNext.wr   = 1'b1;
                busNext.io   = isIo(dstMode);
                busNext.addr = dstReg;
                busNext.data = busRdData;
            end
            default: begin
                busNext.hold = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Flip-flops.

    // Control and state registers.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stateReg  <= dma_ch0_pkg::S_IDLE;
            modeReg   <= dma_ch0_pkg::MODE_RESET;
            enReg     <= 1'b0;
            masterReg <= 1'b0;
            statReg   <= dma_ch0_pkg::STAT_RESET;
            maskReg   <= dma_ch0_pkg::MASK_RESET;
        end else begin
            stateReg  <= stateNext;
            modeReg   <= wMode ? (wd & dma_ch0_pkg::MODE_MASK) : modeReg;
            enReg     <= enNext;
            masterReg <= masterNext;
            statReg   <= statNext;
            maskReg   <= wMask ? wd[1:0] : maskReg;
        end
    end

    // Datapath registers.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            srcReg   <= 16'h0000;
            dstReg   <= 16'h0000;
            cntReg   <= 16'h0000;
            dataReg  <= 8'h00;
            rdataReg <= 8'h00;
            busReg   <= '0;
        end else begin
            srcReg   <= srcNext;
            dstReg   <= dstNext;
            cntReg   <= cntNext;
            dataReg  <= (stateReg == dma_ch0_pkg::S_READ) ? busRdData : dataReg;
            rdataReg <= regReq.rd ? rdMux : 8'h00;
            busReg   <= busNext;
        end
    end

    assign busCyc   = busReg;
    assign regRdata = rdataReg;
    // Mask bit 0 enables only the done interrupt; mask bit 1 enables the bad mode one.
    assign irq      = |(statReg & maskReg);

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    a_src_step_inc: assert property ((stateReg == dma_ch0_pkg::S_WRITE) && srcMode == 2'h0
        && !wSrcLo && !wSrcHi |=> srcReg == $past(srcReg) + 16'h0001)
        else $error("source did not step up");
    a_dst_step_dec: assert property ((stateReg == dma_ch0_pkg::S_WRITE) && dstMode == 2'h1
        && !wDstLo && !wDstHi |=> dstReg == $past(dstReg) - 16'h0001)
        else $error("destination did not step down");
    a_fixed_hold: assert property ((stateReg == dma_ch0_pkg::S_WRITE) && dstMode[1]
        && !wDstLo && !wDstHi |=> $stable(dstReg))
        else $error("fixed destination moved");
    a_bad_mode_idle: assert property (badMode |-> ##1 (stateReg == dma_ch0_pkg::S_IDLE
        || $past(stateReg) != dma_ch0_pkg::S_IDLE))
        else $error("reserved mode started a transfer");
    a_burst_hold: assert property (busCyc.wr && burstSel && !ioPaced && running
        && cntReg > 16'h0001 |=> busCyc.hold && busCyc.rd)
        else $error("burst released the bus");
    a_steal_gap: assert property (busCyc.wr && !burstSel && !ioPaced && running
        && cntReg > 16'h0001 |=> !busCyc.hold ##1 busCyc.rd)
        else $error("cycle steal gap wrong");
    a_io_request: assert property ((stateReg == dma_ch0_pkg::S_IDLE) && ioPaced
        && !ch0ExtRequest |=> stateReg == dma_ch0_pkg::S_IDLE)
        else $error("I/O transfer without request");
    a_mem_self: assert property ((stateReg == dma_ch0_pkg::S_IDLE) && running && !ioPaced
        && !countZero |=> stateReg == dma_ch0_pkg::S_READ)
        else $error("memory transfer did not start");
    a_count_down: assert property (byteDone && !wCntLo && !wCntHi
        |=> cntReg == $past(cntReg) - 16'h0001)
        else $error("count did not decrement");
    a_need_enable: assert property (!(enReg && masterReg) && stateReg == dma_ch0_pkg::S_IDLE
        |=> stateReg == dma_ch0_pkg::S_IDLE)
        else $error("ran while disabled");
    a_end_irq: assert property (byteDone && lastByte && maskReg[0]
        |=> !enReg && statReg[0] && irq)
        else $error("termination not signalled");

    c_burst_run: cover property (busCyc.wr && burstSel ##1 busCyc.rd);
    c_steal_run: cover property (busCyc.wr ##1 !busCyc.hold ##1 busCyc.rd);
    c_io_run:    cover property (ioPaced && byteDone && lastByte);
    c_bad_mode:  cover property (statReg[1]);

endmodule

// ==== sim/bus_partner_model.sv ====
/* Memory and I/O space answering the channel 0 engine's bus cycles.
   Assumes read data are taken in the same cycle as the read strobe. */
`timescale 1ns/10ps
module bus_partner_model (
    // Clock.
    input  wire logic                  clock,
    // Engine bus.
    input  wire dma_ch0_pkg::bus_cyc_t busCyc,
    output logic [7:0]                 busRdData,
    // Peripheral request, commanded by the bench.
    input  wire logic                  reqOn,
    output logic                       ch0ExtRequest
);
    logic [7:0] lastReg = 8'h00;  // Last byte handed out.

    // The peripheral holds a level request while told to.
    assign ch0ExtRequest = reqOn;

    // Data depend on space and address only, so a fixed address is a port.
    // Outside a read the lines flip, so a stale byte never looks valid.
    always_comb begin
        if (busCyc.rd)
            busRdData = busCyc.addr[7:0] ^ (busCyc.io ? 8'hA5 : 8'h5A);
        else
            busRdData = ~lastReg;
    end

    // Remember the byte to invert it afterwards.
    always_ff @(posedge clock) begin
        if (busCyc.rd)
            lastReg <= busRdData;
    end
endmodule

// ==== sim/dma_channel0_mode_control_tb_top.sv ====
/* Self-checking bench for the channel 0 mode and transfer block.
   Assumes the bus partner model answers reads in the cycle of the strobe. */
`timescale 1ns/10ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_count++; \
    $display("wrong value at %0t: got %0h expected %0h", $time, got, exp); end end
module dma_channel0_mode_control_tb_top;
    logic                  clock = 1'b0;  // 40 MHz clock.
    logic                  rst_b;         // Synchronous reset, active low.
    dma_ch0_pkg::reg_req_t regReq;        // Register port request.
    logic [7:0]            regRdata;      // Register read data.
    logic                  masterStop;    // Non-maskable stop event.
    logic                  reqOn;         // Bench command to the peripheral.
    logic                  ch0ExtRequest; // Peripheral request line.
    dma_ch0_pkg::bus_cyc_t busCyc;        // Engine bus cycle.
    logic [7:0]            busRdData;     // Bus read data.
    logic                  irq;           // Interrupt output.
    int                    err_count = 0; // Mismatches seen.
    int                    compares = 0;  // Comparisons made.

    always #12.5 clock = ~clock;

    dma_channel0_mode_control i_dma_channel0_mode_control (
        .clock(clock), .rst_b(rst_b), .regReq(regReq), .regRdata(regRdata),
        .ch0ExtRequest(ch0ExtRequest), .masterStop(masterStop),
        .busCyc(busCyc), .busRdData(busRdData), .irq(irq));
    bus_partner_model i_bus_partner_model (
        .clock(clock), .busCyc(busCyc), .busRdData(busRdData),
        .reqOn(reqOn), .ch0ExtRequest(ch0ExtRequest));

    ////////////////////////////////////////////////////////////////////////
    // Bus tasks and expectations.
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic regWr(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clock);
        regReq <= '0;
    endtask
    // Read data stand only in the cycle after the strobe, so look there.
    task automatic regRd(logic [7:0] a, logic [7:0] e);
        @(posedge clock);
        regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(posedge clock);
        regReq <= '0;
        #1;
        `CHK(regRdata, e)
    endtask
    function automatic logic [15:0] nextAddr(logic [15:0] a, logic [1:0] m);
        return (m == 2'h0) ? a + 16'h0001 : (m == 2'h1) ? a - 16'h0001 : a;
    endfunction

    // One whole transfer in the given mode, checked cycle by cycle.
    task automatic runMode(logic [3:0] code, logic burst, int cnt);
        logic [15:0] s;
        logic [15:0] d;
        logic [1:0]  dm;
        logic [1:0]  sm;
        logic        io;
        logic        mk;
        int          w;
        dm = code[3:2];
        sm = code[1:0];
        io = (dm == 2'h3) || (sm == 2'h3);
        s = 16'($urandom);
        d = 16'($urandom);
        mk = 1'($urandom);
        regWr(8'h20, s[7:0]);
        regWr(8'h21, s[15:8]);
        regWr(8'h22, d[7:0]);
        regWr(8'h23, d[15:8]);
        regWr(8'h24, cnt[7:0]);
        regWr(8'h25, 8'h00);
        regWr(8'h27, {7'h00, mk});
        regWr(8'h31, {2'h0, dm, sm, burst, 1'b0});
        regRd(8'h31, {2'h0, dm, sm, burst, 1'b0});
        regWr(8'h30, 8'h01);
        // A memory-only run must not care what the request line does.
        reqOn <= io ? 1'b0 : 1'($urandom);
        if (dm[1] && sm[1]) begin
            repeat (6) begin tick(); `CHK(busCyc.hold, 1'b0) end
            regRd(8'h26, 8'h02);
            regWr(8'h30, 8'h00);
            regWr(8'h26, 8'h02);
            return;
        end
        for (int i = 0; i < cnt; i++) begin
            if (io) begin
                repeat (2) begin tick(); `CHK(busCyc.hold, 1'b0) end
                @(posedge clock);
                reqOn <= 1'b1;
            end
            // In burst the next read already stands here, so look before waiting.
            #1;
            w = 0;
            while (busCyc.rd !== 1'b1 && w < 20) begin
                tick();
                w++;
            end
            `CHK(busCyc.rd, 1'b1)
            `CHK(busCyc.addr, s)
            `CHK(busCyc.io, sm == 2'h3)
            @(posedge clock);
            reqOn <= io ? 1'b0 : 1'($urandom);
            #1;
            `CHK(busCyc.wr, 1'b1)
            `CHK(busCyc.addr, d)
            `CHK(busCyc.io, dm == 2'h3)
            `CHK(busCyc.data, s[7:0] ^ ((sm == 2'h3) ? 8'hA5 : 8'h5A))
            s = nextAddr(s, sm);
            d = nextAddr(d, dm);
            tick();
            `CHK(busCyc.hold, !io && burst && (i < cnt - 1))
        end
        repeat (3) tick();
        `CHK(irq, mk)
        regRd(8'h26, 8'h01);
        regRd(8'h30, 8'h02);
        regRd(8'h20, s[7:0]);
        regRd(8'h23, d[15:8]);
        regRd(8'h24, 8'h00);
        regWr(8'h26, 8'h01);
        tick();
        `CHK(irq, 1'b0)
    endtask

    task automatic end_of_test();
        if (err_count == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, register corners, every code, then stops.
    initial begin
        void'($urandom(32'h1e995eb6));
        regReq = '0;
        masterStop = 1'b0;
        reqOn = 1'b0;
        rst_b = 1'b0;
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        regRd(8'h31, 8'h00);
        regRd(8'h30, 8'h00);
        regWr(8'h31, 8'hFF);
        regRd(8'h31, 8'h3E);
        regRd(8'h40, 8'h00);
        for (int m = 0; m < 32; m++)
            runMode(m[4:1], m[0], 1 + $urandom_range(2));
        // Enabling with nothing to move completes at once.
        // The last run was a refused mode, so its count must be cleared first.
        regWr(8'h24, 8'h00);
        regWr(8'h31, 8'h00);
        regWr(8'h30, 8'h01);
        tick();
        `CHK(busCyc.hold, 1'b0)
        regRd(8'h26, 8'h01);
        regWr(8'h26, 8'h01);
        // The stop event drops master enable, so a request is not served.
        regWr(8'h24, 8'h01);
        regWr(8'h31, 8'h0C);
        regWr(8'h30, 8'h01);
        masterStop <= 1'b1;
        @(posedge clock);
        masterStop <= 1'b0;
        reqOn <= 1'b1;
        repeat (5) begin tick(); `CHK(busCyc.hold, 1'b0) end
        regRd(8'h30, 8'h01);
        end_of_test();
    end

    // A hang is cut short well after the sequence should end.
    initial begin
        #250000;
        err_count++;
        end_of_test();
    end
endmodule
